// ### hw/mcg_top.sv
// multi-converter group behind a memory-mapped phase-2 processor bus
`timescale 1ns/1ps
module mcg_top #(
   parameter int NUM_CONV   = 8,
   parameter bit FULL_DEC   = 1'b0,
   parameter int CCLK_DIV   = mcg_pkg::CCLK_DIV,
   parameter int CONV_TICKS = mcg_pkg::CCLK_PER_CONV
) (
   // clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  rst_i,
   // processor bus pins
   input  wire logic [15:0]           address_i,
   input  wire logic                  read_not_write_i,
   input  wire logic                  valid_memory_address_i,
   input  wire logic                  bus_phase2_clock_i,
   input  wire logic [7:0]            data_i,
   output logic [7:0]                 data_o,
   output logic                       data_oe_o,
   // analog channels, one byte per converter
   input  wire logic [NUM_CONV*8-1:0] sample_i,
   // combined interrupt request, active low
   output logic                       irq_n_o,
   // per-converter done lines, active low
   output logic [NUM_CONV-1:0]        conversion_done_n_o
);
   // ---------------------------------------------------------------
   // pin synchronisers (three stages, change counted when 2 and 3 agree)
   // ---------------------------------------------------------------
   // shift stages, stage 0 meets the pin
   logic [2:0] s_rnw;
   logic [2:0] s_vma;
   logic [2:0] s_ph2;
   // filtered levels and the delayed phase-2 for edge finding
   logic       rnw;
   logic       valid_memory_address;
   logic       ph2;
   logic       ph2_q;
   logic       next_rnw;
   logic       next_vma;
   logic       next_ph2;

   // reset matches the idle pin levels so no false edge follows reset
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_rnw <= 3'h7;
         s_vma <= 3'h0;
         s_ph2 <= 3'h0;
      end else begin
         s_rnw <= {s_rnw[1:0], read_not_write_i};
         s_vma <= {s_vma[1:0], valid_memory_address_i};
         s_ph2 <= {s_ph2[1:0], bus_phase2_clock_i};
      end
   end

   // filtered levels follow only when stages two and three agree
   always_comb begin
      next_rnw = (s_rnw[1] == s_rnw[2]) ? s_rnw[2] : rnw;
      next_vma = (s_vma[1] == s_vma[2]) ? s_vma[2] : valid_memory_address;
      next_ph2 = (s_ph2[1] == s_ph2[2]) ? s_ph2[2] : ph2;
   end

   // registered filtered levels; ph2_q gives the rising edge of phase 2
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rnw   <= 1'b1;
         valid_memory_address   <= 1'b0;
         ph2   <= 1'b0;
         ph2_q <= 1'b0;
      end else begin
         rnw   <= next_rnw;
         valid_memory_address   <= next_vma;
         ph2   <= next_ph2;
         ph2_q <= ph2;
      end
   end

   // address is held stable through phase 2 by the bus, so sample it plainly there
   // ---------------------------------------------------------------
   // decode and strobes
   // ---------------------------------------------------------------
   function automatic logic page_hit(input logic [15:0] a);
      page_hit = a[mcg_pkg::PAGE_MSB:mcg_pkg::PAGE_LSB]
                 == mcg_pkg::BASE_ADDR[mcg_pkg::PAGE_MSB:mcg_pkg::PAGE_LSB];
   endfunction : page_hit

   // decode results
   logic       cs;
   logic       ph2_rise;
   logic       wr_stb;
   logic       rd_act;
   logic [2:0] sel;

   // chip select and strobes from the synchronised controls, reader index from the plain address pins
   always_comb begin
      cs = valid_memory_address && page_hit(address_i);
      // full decode trades a wider compare for no aliasing across the page
      if (FULL_DEC) begin
         cs = cs && (address_i[mcg_pkg::PAGE_LSB-1:mcg_pkg::SEL_BITS] == mcg_pkg::FULL_MASK_HI);
      end
      ph2_rise = ph2 && !ph2_q;
      wr_stb   = cs && !rnw && ph2_rise;
      rd_act   = cs && rnw && ph2;
      // three select bits cap one group at eight readers
      sel      = address_i[mcg_pkg::SEL_BITS-1:0];
   end

   // ---------------------------------------------------------------
   // shared conversion clock from one divider in the top, outside the converters
   // ---------------------------------------------------------------
   logic [15:0] div_cnt;
   logic [15:0] next_div_cnt;
   logic        cclk_tick;
   logic        next_cclk_tick;

   // a single divider feeds every channel so they never drift apart
   always_comb begin
      next_cclk_tick = 1'b0;
      next_div_cnt   = div_cnt + 16'h0001;
      if (div_cnt == 16'(CCLK_DIV - 1)) begin
         next_div_cnt   = 16'h0000;
         next_cclk_tick = 1'b1;
      end
   end

   // tick is registered so every channel sees it in the same cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         div_cnt   <= 16'h0000;
         cclk_tick <= 1'b0;
      end else begin
         div_cnt   <= next_div_cnt;
         cclk_tick <= next_cclk_tick;
      end
   end

   // ---------------------------------------------------------------
   // converters
   // ---------------------------------------------------------------
   // per-channel done and result
   logic [NUM_CONV-1:0] done_n;
   logic [7:0]          res [NUM_CONV];

   // every channel gets the same start and tick, so all sample at once
   for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
      mcg_conv #(.CONV_TICKS(CONV_TICKS)) u_conv (
         .clock_i             (clock_i),
         .rst_i               (rst_i),
         .cclk_tick_i         (cclk_tick),
         .start_i             (wr_stb),
         .sample_i            (sample_i[g*8 +: 8]),
         .conversion_done_n_o (done_n[g]),
         .result_o            (res[g])
      );
   end

   // ---------------------------------------------------------------
   // read path, interrupt and done outputs
   // ---------------------------------------------------------------
   logic [NUM_CONV-1:0] rd_en;
   logic [7:0]          rd_mux;
   logic [7:0]          next_data;
   logic                next_oe;
   logic                next_irq_n;

   // one-hot read enable: at most one converter ever feeds the shared bus
   always_comb begin
      rd_en  = '0;
      rd_mux = 8'h00;
      for (int i = 0; i < NUM_CONV; i++) begin
         rd_en[i] = rd_act && (int'(sel) == i);
         if (rd_en[i]) begin
            rd_mux = res[i];
         end
      end
   end

   // addresses past the last converter leave the bus undriven
   always_comb begin
      next_oe    = |rd_en;
      next_data  = rd_mux;
      next_irq_n = !(&(~done_n));
   end

   // ---------------------------------------------------------------
   // output registers: every port leaves straight from a flip-flop
   // ---------------------------------------------------------------

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         data_o              <= 8'h00;
         data_oe_o           <= 1'b0;
         irq_n_o             <= 1'b1;
         conversion_done_n_o <= '1;
      end else begin
         data_o              <= next_data;
         data_oe_o           <= next_oe;
         irq_n_o             <= next_irq_n;
         conversion_done_n_o <= done_n;
      end
   end

   // data_i is unused: writes only start conversions, their data are ignored
   logic unused_data;
   assign unused_data = ^data_i;
endmodule : mcg_top

// ### common/mcg_pkg.sv
// package of constants for the multi-converter bus glue
package mcg_pkg;
   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam logic [15:0] BASE_ADDR     = 16'h5000;
   localparam int          PAGE_MSB      = 15;
   localparam int          PAGE_LSB      = 12;
   localparam int          SEL_BITS      = 3;
   localparam logic [8:0]  FULL_MASK_HI  = 9'h000;
   // ---------------------------------------------------------------
   // converter model timing
   // ---------------------------------------------------------------
   localparam int          CLK_MHZ       = 100;
   localparam int          CONV_US       = 100;
   localparam int          CONV_CYCLES   = CONV_US * CLK_MHZ;
   localparam int          CCLK_DIV      = 78;
   localparam int          CCLK_PER_CONV = 64;
   localparam logic [7:0]  RESULT_RESET  = 8'h00;
endpackage : mcg_pkg

// ### hw/mcg_conv.sv
// one converter channel: start latch, done flag, sampled result register
`timescale 1ns/1ps
module mcg_conv #(
   parameter int CONV_TICKS = mcg_pkg::CCLK_PER_CONV
) (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // shared conversion clock tick and start
   input  wire logic       cclk_tick_i,
   input  wire logic       start_i,
   // analog sample, already digitised at the shared sampling instant
   input  wire logic [7:0] sample_i,
   // status and result
   output logic            conversion_done_n_o,
   output logic [7:0]      result_o
);
   logic [7:0]  held;
   logic [7:0]  next_held;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic        busy;
   logic        next_busy;
   logic        done_n;
   logic        next_done_n;
   logic [7:0]  res;
   logic [7:0]  next_res;

   // sample at start, count shared clock ticks, publish result
   always_comb begin
      next_held   = held;
      next_cnt    = cnt;
      next_busy   = busy;
      next_done_n = done_n;
      next_res    = res;
      if (start_i) begin
         next_held   = sample_i;
         next_cnt    = 16'h0000;
         next_busy   = 1'b1;
         next_done_n = 1'b1;
      end else if (busy && cclk_tick_i) begin
         if (cnt == 16'(CONV_TICKS - 1)) begin
            next_busy   = 1'b0;
            next_res    = held;
            next_done_n = 1'b0;
         end else begin
            next_cnt = cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         held   <= mcg_pkg::RESULT_RESET;
         cnt    <= 16'h0000;
         busy   <= 1'b0;
         done_n <= 1'b1;
         res    <= mcg_pkg::RESULT_RESET;
      end else begin
         held   <= next_held;
         cnt    <= next_cnt;
         busy   <= next_busy;
         done_n <= next_done_n;
         res    <= next_res;
      end
   end

   assign conversion_done_n_o = done_n;
   assign result_o            = res;
endmodule : mcg_conv

// ### dv/mcg_top_asserts.sv
// checker for the bus glue top ports
`timescale 1ns/1ps
module mcg_top_asserts #(
   parameter int NUM_CONV = 8
) (
   // clock, reset and host bus
   input wire logic                clock_i,
   input wire logic                rst_i,
   input wire logic [15:0]         address_i,
   input wire logic                read_not_write_i,
   input wire logic                valid_memory_address_i,
   input wire logic                bus_phase2_clock_i,
   // outputs watched
   input wire logic [7:0]          data_o,
   input wire logic                data_oe_o,
   input wire logic                irq_n_o,
   input wire logic [NUM_CONV-1:0] conversion_done_n_o
);
   // ---
   // cycles since a strobed access, saturating so it never wraps
   // ---
   logic [3:0] wr_age, rd_age, next_wr_age, next_rd_age;
   logic       pg;
   always_comb begin
      pg = valid_memory_address_i && bus_phase2_clock_i && address_i[15:12] == 4'h5;
      next_wr_age = (pg && !read_not_write_i) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
      next_rd_age = (pg && read_not_write_i) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
   end
   always_ff @(posedge clock_i) begin
      wr_age <= rst_i ? 4'hf : next_wr_age;
      rd_age <= rst_i ? 4'hf : next_rd_age;
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   sequence s_all_done;
      conversion_done_n_o == '0;
   endsequence
   a_irq_after_done: assert property (s_all_done |-> !irq_n_o)
      else $error("irq missing after all done");
   a_irq_needs_all: assert property (!irq_n_o |-> conversion_done_n_o == '0)
      else $error("irq without all done");
   a_irq_cleared: assert property (conversion_done_n_o != '0 |-> irq_n_o)
      else $error("irq stuck while busy");
   a_done_together: assert property (conversion_done_n_o == '0 || conversion_done_n_o == '1)
      else $error("converters out of step");
   a_start_by_write: assert property ($rose(conversion_done_n_o[0]) |-> wr_age <= 4'h8)
      else $error("start without write");
   a_read_strobed: assert property (data_oe_o |-> rd_age <= 4'h7)
      else $error("data driven without read");
   a_idle_data_zero: assert property (!data_oe_o |-> data_o == 8'h00)
      else $error("data not zero when idle");
   a_data_steady: assert property (data_oe_o && $past(data_oe_o, 2) |-> $stable(data_o))
      else $error("read data moved");
   a_reset_idle: assert property (disable iff (1'b0)
      rst_i |=> irq_n_o && conversion_done_n_o == '1 && !data_oe_o)
      else $error("outputs not idle in reset");
endmodule : mcg_top_asserts

// ### dv/mcg_host_model.sv
// host bus master model for the phase-2 memory bus
`timescale 1ns/1ps
module mcg_host_model (
   // clock and read data
   input  wire logic       clock_i,
   input  wire logic [7:0] data_i,
   input  wire logic       data_oe_i,
   // bus pins
   output logic [15:0]     address_o,
   output logic            read_not_write_o,
   output logic            valid_memory_address_o,
   output logic            bus_phase2_clock_o
);
   // direct attachment: select and read come from decode, not tied active
   // only this glue answers anywhere in page 5
   initial begin
      address_o = 16'h0000;
      read_not_write_o = 1'b1;
      valid_memory_address_o = 1'b0;
      bus_phase2_clock_o = 1'b0;
   end
   // one cycle; pins held past phase-2 fall since the glue sees them late
   task automatic cycle(input logic [15:0] a, input logic rnw, input logic v,
                        output logic [7:0] d, output logic oe);
      @(negedge clock_i);
      address_o = a;
      read_not_write_o = rnw;
      valid_memory_address_o = v;
      repeat (2) @(negedge clock_i);
      bus_phase2_clock_o = 1'b1;
      repeat (8) @(negedge clock_i);
      d = data_i;
      oe = data_oe_i;
      bus_phase2_clock_o = 1'b0;
      repeat (6) @(negedge clock_i);
      valid_memory_address_o = 1'b0;
      address_o = ~a; // released lines show no stale address
      read_not_write_o = 1'b1;
   endtask : cycle
endmodule : mcg_host_model

// ### dv/tb_top.sv
// self-checking bench for the multi-converter bus glue
`timescale 1ns/1ps
module tb_top;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] address_i;
   logic        read_not_write_i, valid_memory_address_i, bus_phase2_clock_i;
   logic [7:0]  data_o, rd, conversion_done_n_o;
   logic        data_oe_o, irq_n_o, oe;
   logic [63:0] sample_i = 64'h0;
   int          n_errors = 0;
   int          num_checks = 0;
   logic [23:0] rows [8] = '{24'h5000a5, 24'h50013c, 24'h5002f0, 24'h50030f,
                             24'h500481, 24'h500518, 24'h50067e, 24'h5007c3};
   always #5 clock_i = ~clock_i;
   // short divider and count keep conversions brief
   mcg_top #(.NUM_CONV(8), .FULL_DEC(1'b0), .CCLK_DIV(2), .CONV_TICKS(4)) mcg_top_i (
      .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
      .read_not_write_i(read_not_write_i), .valid_memory_address_i(valid_memory_address_i),
      .bus_phase2_clock_i(bus_phase2_clock_i), .data_i(8'h00), .data_o(data_o),
      .data_oe_o(data_oe_o), .sample_i(sample_i), .irq_n_o(irq_n_o),
      .conversion_done_n_o(conversion_done_n_o));
   mcg_host_model mcg_host_model_i (
      .clock_i(clock_i), .data_i(data_o), .data_oe_i(data_oe_o), .address_o(address_i),
      .read_not_write_o(read_not_write_i), .valid_memory_address_o(valid_memory_address_i),
      .bus_phase2_clock_o(bus_phase2_clock_i));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic [15:0] a, input logic rnw, input logic v);
      mcg_host_model_i.cycle(a, rnw, v, rd, oe);
   endtask : bus
   task automatic wait_irq;
      for (int i = 0; i < 300 && irq_n_o !== 1'b0; i++) @(negedge clock_i);
      chk({15'h0, irq_n_o}, 16'h0000);
   endtask : wait_irq
   task summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   initial begin
      for (int k = 0; k < 8; k++) sample_i[8*k +: 8] = rows[k][7:0];
      repeat (5) @(negedge clock_i);
      chk({7'h0, irq_n_o, conversion_done_n_o}, 16'h01ff);
      rst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      bus(16'h5000, 1'b0, 1'b1);
      wait_irq();
      chk({8'h0, conversion_done_n_o}, 16'h0000);
      $display("end start and wait");
      sample_i = ~sample_i;
      // results read in order, each from its own converter
      for (int k = 0; k < 8; k++) begin
         bus(rows[k][23:8], 1'b1, 1'b1);
         chk({7'h0, oe, rd}, {8'h01, rows[k][7:0]});
      end
      $display("end reads");
      bus(16'h5000, 1'b0, 1'b0);
      chk({7'h0, irq_n_o, conversion_done_n_o}, 16'h0000);
      bus(16'h5000, 1'b1, 1'b0);
      chk({7'h0, oe, rd}, 16'h0000);
      bus(16'h6003, 1'b1, 1'b1);
      chk({7'h0, oe, rd}, 16'h0000);
      bus(16'h5ab3, 1'b1, 1'b1);
      chk({7'h0, oe, rd}, {8'h01, rows[3][7:0]});
      $display("end refusals");
      bus(16'h5fff, 1'b0, 1'b1);
      wait_irq();
      bus(16'h5002, 1'b1, 1'b1);
      chk({7'h0, oe, rd}, {8'h01, ~rows[2][7:0]});
      $display("end alias restart");
      // reset in mid-run drops every flag and every held result
      rst_i = 1'b1;
      repeat (5) @(negedge clock_i);
      chk({7'h0, irq_n_o, conversion_done_n_o}, 16'h01ff);
      rst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      bus(16'h5000, 1'b1, 1'b1);
      chk({7'h0, oe, rd}, {8'h01, mcg_pkg::RESULT_RESET});
      $display("end mid-run reset");
      summarize();
   end
endmodule : tb_top
bind mcg_top mcg_top_asserts #(.NUM_CONV(NUM_CONV)) mcg_top_asserts_i (
   .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
   .read_not_write_i(read_not_write_i), .valid_memory_address_i(valid_memory_address_i),
   .bus_phase2_clock_i(bus_phase2_clock_i), .data_o(data_o), .data_oe_o(data_oe_o),
   .irq_n_o(irq_n_o), .conversion_done_n_o(conversion_done_n_o));
